// ===== inc/ddc_defs.svh
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
// ****************************************
// register map
// ****************************************
`define DDC_OFS_CTRL      8'h00
`define DDC_OFS_SWTRIG    8'h04
`define DDC_CTRL_RESET    32'h00000000
`define DDC_SWTRIG_RESET  2'h0
// ****************************************
// field positions, channel zero; channel one adds the half offset
// ****************************************
`define DDC_CH_OFS        16
`define DDC_POS_EN        0
`define DDC_POS_BOFF      1
`define DDC_POS_TEN       2
`define DDC_POS_TSEL      3
`define DDC_POS_WAVE      6
`define DDC_POS_WIDTH     8
`define DDC_POS_DMA       12
`define DDC_CH_MASK       16'h1fff
`define DDC_TSEL_EXT9     3'h6
`define DDC_TSEL_SOFT     3'h7
`define DDC_WIDTH_MAX     4'hb
`define DDC_LFSR_SEED     12'haaa
`endif

// ===== inc/ddc_pkg.sv
package ddc_pkg;
  typedef enum logic [1:0] {
    DDC_TRI_UP,
    DDC_TRI_DOWN
  } ddc_tri_dir_t;
  typedef logic [11:0] ddc_sample_t;
endpackage : ddc_pkg

// ===== hdl/ddc_top.sv
`timescale 1ns/1ps
`include "ddc_defs.svh"
// Operation
// R1 - software uses word accesses to control register
// R2 - per-channel converter enable bits 0/16
// R3 - buffer-off bits 1/17 disable output buffer
// R4 - trigger enable bits 2/18
// R5 - trigger source select, only when enabled
// R6 - wave kind active while trigger enabled
// R7 - width code plus one, capped 12
// R8 - noise masks LFSR above width
// R9 - triangle amplitude (2<<(n-1))-1
// R10 - DMA enable bits 12/28
// R11 - channel one mirrors channel zero layout
// R12 - software trigger register at 0x04
// R13 - software writes one to trigger
// R14 - hardware clears software trigger when taken
// R15 - software writes reserved bits zero
// R16 - transfer on trigger, else automatic
// R17 - external rising edge, software by bit
// R18 - DMA request on hardware trigger only
// R19 - output is holding plus wave
// R20 - synchronise external triggers, edge pulse
// R21 - wave steps once per accepted trigger
module ddc_top
  import ddc_pkg::*;
#(
  parameter int NCH  = 2,
  parameter int NSRC = 7
) (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // timer outputs 5,2,6,4,1,3 in select order, then line nine
  input  wire logic [NSRC-1:0]      trigger_in,
  input  wire logic [NCH*12-1:0]    holding_value,
  output logic      [NCH*12-1:0]    output_value,
  output logic      [NCH-1:0]       chan_convert_on,
  output logic      [NCH-1:0]       chan_buffer_disable,
  output logic      [NCH-1:0]       dma_request
);
  // ****************************************
  // register file
  // ****************************************
  logic [31:0]    ctrl_q, ctrl_d;
  logic [NCH-1:0] swt_q, swt_d;
  logic [31:0]    rdata_q, rdata_d;
  logic [NCH-1:0] soft_take;

  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 32'h00000000;
    // R1 - whole-word write
    if (reg_wr && reg_addr == `DDC_OFS_CTRL) begin
      // R15 - reserved kept zero
      ctrl_d = reg_wdata & {`DDC_CH_MASK, `DDC_CH_MASK};
    end
    // R12 - trigger register, hardware clear
    // R14 - cleared when taken; a new write wins over the clear
    swt_d = swt_q & ~soft_take;
    // R13 - write one sets
    if (reg_wr && reg_addr == `DDC_OFS_SWTRIG) begin
      swt_d = swt_d | reg_wdata[NCH-1:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `DDC_OFS_CTRL:   rdata_d = ctrl_q;
        `DDC_OFS_SWTRIG: rdata_d = {{(32-NCH){1'b0}}, swt_q};
        default:         rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_q  <= `DDC_CTRL_RESET;
      swt_q   <= `DDC_SWTRIG_RESET;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q  <= ctrl_d;
      swt_q   <= swt_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ****************************************
  // trigger synchronisers
  // ****************************************
  logic [NSRC-1:0] sy1_q, sy2_q, sy3_q, lvl_q;
  logic [NSRC-1:0] sy1_d, sy2_d, sy3_d, lvl_d;
  logic [NSRC-1:0] rise;

  always_comb begin
    // R20 - three stages, change once stages two and three agree
    sy1_d = trigger_in;
    sy2_d = sy1_q;
    sy3_d = sy2_q;
    lvl_d = lvl_q;
    for (int i = 0; i < NSRC; i++) begin
      if (sy2_q[i] == sy3_q[i]) begin
        lvl_d[i] = sy3_q[i];
      end
    end
    // R17 - rising edge only
    rise = lvl_d & ~lvl_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
      lvl_q <= '0;
    end else begin
      sy1_q <= sy1_d;
      sy2_q <= sy2_d;
      sy3_q <= sy3_d;
      lvl_q <= lvl_d;
    end
  end

  // ****************************************
  // per-channel wave and output
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // R11 - same layout, upper half for channel one
    localparam int B = c * `DDC_CH_OFS;
    logic        ten;
    logic [2:0]  tsel;
    logic [1:0]  wave;
    logic [3:0]  wcode;
    logic        hw_ev, sw_ev, ev;
    logic [11:0] mask, noise, sum;
    ddc_sample_t  lfsr_q, lfsr_d, tri_q, tri_d, out_q, out_d;
    ddc_tri_dir_t dir_q, dir_d;
    logic        dma_q, dma_d;

    // R2 - converter enable
    assign chan_convert_on[c] = ctrl_q[B + `DDC_POS_EN];
    // R3 - buffer off when set
    assign chan_buffer_disable[c] = ctrl_q[B + `DDC_POS_BOFF];
    // R4 - trigger enable
    assign ten   = ctrl_q[B + `DDC_POS_TEN];
    assign tsel  = ctrl_q[B + `DDC_POS_TSEL +: 3];
    assign wave  = ctrl_q[B + `DDC_POS_WAVE +: 2];
    assign wcode = ctrl_q[B + `DDC_POS_WIDTH +: 4];

    always_comb begin
      // R5 - source picked only with trigger enabled
      hw_ev = ten && tsel != `DDC_TSEL_SOFT && rise[tsel];
      sw_ev = ten && tsel == `DDC_TSEL_SOFT && swt_q[c];
      soft_take[c] = sw_ev;
      ev = hw_ev || sw_ev;
      // R7 - width is code plus one, capped
      // R9 - mask doubles as triangle amplitude
      if (wcode >= `DDC_WIDTH_MAX) begin
        mask = 12'hfff;
      end else begin
        mask = 12'((13'h2 << wcode) - 13'h1);
      end
      // R8 - upper LFSR bits masked
      noise = 12'h000;
      // R6 - wave kind only with trigger enabled
      if (ten && wave == 2'h1) begin
        noise = lfsr_q & mask;
      end else if (ten && wave[1]) begin
        noise = tri_q;
      end
      lfsr_d = lfsr_q;
      tri_d  = tri_q;
      dir_d  = dir_q;
      // R21 - step once per accepted trigger
      if (ev && wave == 2'h1) begin
        lfsr_d = {lfsr_q[10:0], lfsr_q[11] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0]};
      end else if (ev && wave[1]) begin
        unique case (dir_q)
          DDC_TRI_UP: begin
            if (tri_q >= mask) begin
              dir_d = DDC_TRI_DOWN;
              tri_d = (mask == 12'h000) ? 12'h000 : 12'(mask - 12'h1);
            end else begin
              tri_d = 12'(tri_q + 12'h1);
            end
          end
          DDC_TRI_DOWN: begin
            if (tri_q == 12'h000) begin
              dir_d = DDC_TRI_UP;
              tri_d = (mask == 12'h000) ? 12'h000 : 12'h001;
            end else begin
              tri_d = 12'(tri_q - 12'h1);
            end
          end
          default: dir_d = DDC_TRI_UP;
        endcase
      end
      // R19 - holding plus wave, wraps at twelve bits
      sum = 12'(holding_value[c*12 +: 12] + noise);
      // R16 - triggered or automatic transfer
      out_d = out_q;
      if (!ten || ev) begin
        out_d = sum;
      end
      // R10 - DMA enable
      // R18 - hardware trigger only
      dma_d = hw_ev && ctrl_q[B + `DDC_POS_DMA];
    end

    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        lfsr_q <= `DDC_LFSR_SEED;
        tri_q  <= 12'h000;
        dir_q  <= DDC_TRI_UP;
        out_q  <= 12'h000;
        dma_q  <= 1'b0;
      end else begin
        lfsr_q <= lfsr_d;
        tri_q  <= tri_d;
        dir_q  <= dir_d;
        out_q  <= out_d;
        dma_q  <= dma_d;
      end
    end
    assign output_value[c*12 +: 12] = out_q;
    assign dma_request[c] = dma_q;
  end
endmodule : ddc_top

// ===== verif/ddc_chk.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module ddc_chk #(
  parameter int NCH = 2
) (
  input wire logic           ref_clk,
  input wire logic           nrst,
  input wire logic [7:0]     reg_addr,
  input wire logic [31:0]    reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [31:0]    reg_rdata,
  input wire logic [NCH-1:0] chan_convert_on,
  input wire logic [NCH-1:0] chan_buffer_disable,
  input wire logic [NCH-1:0] dma_request
);
  logic cw;
  logic cr;
  assign cw = reg_wr && reg_addr == 8'h00;
  assign cr = reg_rd && reg_addr == 8'h00;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("rdata not idle");
  chk_ctrl_rb: assert property (cw ##1 cr |=> reg_rdata == ($past(reg_wdata, 2) & 32'h1fff1fff))
    else $error("ctrl readback");
  chk_conv_on: assert property (cw |=> chan_convert_on == {$past(reg_wdata[16]), $past(reg_wdata[0])})
    else $error("convert bits");
  chk_buf_off: assert property (cw |=> chan_buffer_disable == {$past(reg_wdata[17]), $past(reg_wdata[1])})
    else $error("buffer bits");
  chk_swt_resv: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:2] == 30'h0)
    else $error("soft reg reserved");
  chk_unmapped: assert property (reg_rd && reg_addr > 8'h04 |=> reg_rdata == 32'h0)
    else $error("unmapped read");
  chk_dma_one: assert property (dma_request[0] |=> !dma_request[0])
    else $error("dma pulse 0");
  chk_dma_two: assert property (dma_request[1] |=> !dma_request[1])
    else $error("dma pulse 1");
  cover property (dma_request[0]);
  cover property (cw ##1 cr);
  cover property (reg_wr && reg_addr == 8'h04);
endmodule : ddc_chk
bind ddc_top ddc_chk #(.NCH(NCH)) ddc_chk_inst (.ref_clk(ref_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .chan_convert_on(chan_convert_on),
  .chan_buffer_disable(chan_buffer_disable), .dma_request(dma_request));

// ===== verif/ddc_partner.sv
`timescale 1ns/1ps
// ****
// timers, line nine, dma
// ****
module ddc_partner (
  input  wire logic       ref_clk,
  input  wire logic [1:0] dma_request,
  output logic      [6:0] trigger_in,
  output logic      [7:0] dma_count
);
  initial trigger_in = 7'h00;
  initial dma_count = 8'h00;
  // level held past the sync stages
  task automatic pulse(input int src);
    @(posedge ref_clk) trigger_in[src] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    trigger_in[src] <= 1'b0;
  endtask : pulse
  always @(posedge ref_clk) dma_count <= dma_count + 8'(dma_request[0]);
endmodule : ddc_partner

// ===== verif/ddc_top_tb_top.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module ddc_top_tb_top;
  typedef struct {logic [31:0] w, r; logic [1:0] c, b;} ddc_row_t;
  logic        ref_clk, nrst, reg_wr, reg_rd;
  logic [7:0]  reg_addr, dma_count;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [6:0]  trigger_in;
  logic [23:0] hold, out;
  logic [1:0]  conv, boff, dma;
  int          n_mismatch, n_tests, i, k;
  ddc_row_t    rows [4] = '{'{32'h00010002, 32'h00010002, 2'h2, 2'h1},
    '{32'hffffffff, 32'h1fff1fff, 2'h3, 2'h3}, '{32'h10021001, 32'h10021001, 2'h1, 2'h2},
    '{32'h0, 32'h0, 2'h0, 2'h0}};
  ddc_top ddc_top_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trigger_in(trigger_in), .holding_value(hold), .output_value(out),
    .chan_convert_on(conv), .chan_buffer_disable(boff), .dma_request(dma));
  ddc_partner ddc_partner_inst (.ref_clk(ref_clk), .dma_request(dma),
    .trigger_in(trigger_in), .dma_count(dma_count));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic finish_test;
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    tick(5000);
    n_mismatch++;
    finish_test;
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, hold} = '0;
    tick(10);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00); chk("ctrl rst", 32'h0, v);
    rd(8'h04); chk("soft rst", 32'h0, v);
    rd(8'h08); chk("unmapped", 32'h0, v);
    for (i = 0; i < 4; i++) begin
      wr(8'h00, rows[i].w);
      rd(8'h00); chk("ctrl", rows[i].r, v);
      chk("conv", {30'h0, rows[i].c}, {30'h0, conv});
      chk("boff", {30'h0, rows[i].b}, {30'h0, boff});
    end
    hold <= 24'h456123;
    tick(3); chk("follow", 32'h456123, {8'h0, out});
    wr(8'h00, 32'h0000003c);
    hold <= 24'h456200;
    tick(3); chk("no auto", 32'h123, {20'h0, out[11:0]});
    wr(8'h04, 32'h1);
    tick(3); chk("soft", 32'h200, {20'h0, out[11:0]});
    rd(8'h04); chk("soft clr", 32'h0, v);
    wr(8'h00, 32'h00001034);
    hold <= 24'h456300;
    ddc_partner_inst.pulse(0);
    tick(3); chk("other src", 32'h200, {20'h0, out[11:0]});
    ddc_partner_inst.pulse(6);
    tick(3); chk("line nine", 32'h300, {20'h0, out[11:0]});
    chk("dma", 32'h1, {24'h0, dma_count});
    hold <= 24'h456010;
    for (k = 1; k < 3; k++) begin
      wr(8'h00, 32'(k << 6) | 32'h3c);
      tick(1);
      for (i = 0; i < 4; i++) begin
        wr(8'h04, 32'h1);
        tick(3); chk("wave", 32'h8, {21'h0, out[11:1]});
      end
    end
    nrst <= 1'b0;
    tick(3);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00); chk("ctrl rst2", 32'h0, v);
    chk("conv rst2", 32'h0, {30'h0, conv});
    finish_test;
  end
endmodule : ddc_top_tb_top
